// file: core/ptb_regs.vh
// Offsets, reset values, region map and timing counts of the pass-through
`ifndef PTB_REGS_VH
`define PTB_REGS_VH

// Add-on register offset of the pass-through data buffer
`define PTB_DATA_OFFSET 7'h2C
`define PTB_DATA_RESET 32'h0000_0000

// Region map: base and match mask, region 1 answers with code 01
`define PTB_RGN0_BASE 32'h000C_0000
`define PTB_RGN0_MASK 32'hFFFF_F000
`define PTB_RGN1_BASE 32'h000D_C000
`define PTB_RGN1_MASK 32'hFFFF_FE00
`define PTB_RGN2_BASE 32'h000D_C200
`define PTB_RGN2_MASK 32'hFFFF_FE00
`define PTB_RGN3_BASE 32'h000E_0000
`define PTB_RGN3_MASK 32'hFFFF_0000

// Command bit 0 set means a write cycle
`define PTB_CMD_WRITE_BIT 0

// Data phase limits, in PCI clocks
`define PTB_FIRST_PHASE_CLKS 16
`define PTB_BURST_PHASE_CLKS 8

`endif

// file: core/ptb_bridge.v
// Pass-through target bridge between the PCI target pins and add-on logic
`timescale 1ns/10ps
`include "ptb_regs.vh"

module ptb_bridge (
    // Clock, reset and freeze
    input wire clk,
    input wire rst_n,
    input wire clkEn,
    // PCI target pins
    input wire frameN,
    input wire irdyN,
    input wire [31:0] adIn,
    input wire [3:0] cbeN,
    output wire [31:0] adOut,
    output wire adOe,
    output wire devselN,
    output wire trdyN,
    output wire stopN,
    output wire pciCtlOe,
    // Add-on register access pins
    input wire addonSelectN,
    input wire addonRdN,
    input wire addonWrN,
    input wire [6:2] addonAdr,
    input wire [3:0] addonLaneEnablesN,
    input wire [31:0] addonDataIn,
    output wire [31:0] addonDataOut,
    output wire addonDataOe,
    // Pass-through handshake and status
    input wire addressOutputSelectN,
    input wire addonCompletionN,
    output wire passthruAttentionN,
    output wire burstIndicatorN,
    output wire [1:0] regionIdentifier,
    output wire [3:0] laneEnableOutputsN,
    output wire writeDirection
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_WDATA = 3'h1;
    localparam [2:0] S_RWAIT = 3'h2;
    localparam [2:0] S_RDATA = 3'h3;
    localparam [2:0] S_RETRY = 3'h4;

    localparam [4:0] FIRST_LAST = `PTB_FIRST_PHASE_CLKS - 1;
    localparam [4:0] BURST_LAST = `PTB_BURST_PHASE_CLKS - 1;

    localparam [127:0] RGN_BASE = {`PTB_RGN3_BASE, `PTB_RGN2_BASE,
        `PTB_RGN1_BASE, `PTB_RGN0_BASE};
    localparam [127:0] RGN_MASK = {`PTB_RGN3_MASK, `PTB_RGN2_MASK,
        `PTB_RGN1_MASK, `PTB_RGN0_MASK};

    // Write buffer entry: burst, lanes, address, data
    localparam BUF_W = 69;
    localparam BUF_D = 2;

    // Region decode: hit bit over region number
    function [2:0] regionOf;
        input [31:0] a;
        integer i;
        begin
            regionOf = 3'h0;
            for (i = 3; i >= 0; i = i - 1) begin
                if ((a & RGN_MASK[i*32 +: 32]) == RGN_BASE[i*32 +: 32]) begin
                    regionOf = {1'b1, i[1:0]};
                end
            end
        end
    endfunction

    reg [2:0] stateFf;
    reg frameDlyFf;
    reg devselNFf, trdyNFf, stopNFf, ctlOeFf, adOeFf;
    reg [31:0] adOutFf;
    reg [31:0] phaseAddrFf;
    reg [1:0] regionFf;
    reg [4:0] waitCntFf;
    reg firstFf;
    reg readPendFf, readDoneFf, readBurstFf;
    reg [1:0] pendRegionFf;
    reg [31:0] pendAddrFf;
    reg [3:0] pendLaneFf;
    reg coolFf;
    reg attnNFf, burstNFf, wrDirFf;
    reg [1:0] regionIdFf;
    reg [3:0] laneOutFf;
    reg [31:0] passthruDataBufferFf;
    reg [BUF_W-1:0] bufMem [0:BUF_D-1];
    reg wrPtrFf, rdPtrFf;
    reg [1:0] bufCountFf;

    reg [2:0] nxt_state;
    reg nxt_devselN, nxt_trdyN, nxt_stopN, nxt_ctlOe, nxt_adOe;
    reg [31:0] nxt_adOut, nxt_phaseAddr, nxt_pendAddr;
    reg [1:0] nxt_region, nxt_pendRegion;
    reg [4:0] nxt_waitCnt;
    reg nxt_first, nxt_readPend, nxt_readDone, nxt_readBurst;
    reg [3:0] nxt_pendLane;
    reg push;

    wire [2:0] hit = regionOf(adIn);
    wire [31:0] stepAddr = phaseAddrFf + 32'h0000_0004;
    wire stepInRegion = (regionOf(stepAddr) == {1'b1, regionFf});
    wire addrPhase = !frameN && frameDlyFf;
    wire xfer = !irdyN && !trdyNFf;
    wire [4:0] limit = firstFf ? FIRST_LAST : BURST_LAST;
    wire timeout = (waitCntFf >= limit);

    // Add-on side decode and completion
    wire dataSel = !addonSelectN && ({addonAdr, 2'b00} == `PTB_DATA_OFFSET);
    wire addonRead = dataSel && !addonRdN && addressOutputSelectN;
    wire addonWrite = dataSel && !addonWrN && addressOutputSelectN;
    wire complete = !addonCompletionN && !attnNFf;
    wire pop = complete && (bufCountFf != 2'h0);
    wire [BUF_W-1:0] headEntry = bufMem[rdPtrFf];
    wire [BUF_W-1:0] pushEntry = {!frameN, cbeN, phaseAddrFf, adIn};
    wire [1:0] afterPop = bufCountFf - {1'b0, pop};
    wire [1:0] nxtCount = afterPop + {1'b0, push};
    wire room = (afterPop < 2'h2);
    wire [BUF_W-1:0] nxtHead = (afterPop == 2'h0) ? pushEntry :
        bufMem[rdPtrFf ^ pop];
    wire [31:0] holderAddr = (bufCountFf != 2'h0) ? headEntry[63:32] :
        pendAddrFf;
    wire [31:0] regData = (bufCountFf != 2'h0) ? headEntry[31:0] :
        passthruDataBufferFf;
    // Count after a push in the same cycle, for the next TRDY
    wire [1:0] nxtCountPush = afterPop + 2'h1;
    // Reset image of the data buffer, sliced per lane below
    localparam [31:0] DATA_RST = `PTB_DATA_RESET;

    // PCI target sequencing
    always @* begin
        nxt_state = stateFf;
        nxt_devselN = devselNFf;
        nxt_trdyN = 1'b1;
        nxt_stopN = 1'b1;
        nxt_ctlOe = ctlOeFf;
        nxt_adOe = 1'b0;
        nxt_adOut = adOutFf;
        nxt_phaseAddr = phaseAddrFf;
        nxt_region = regionFf;
        nxt_waitCnt = waitCntFf + 5'h01;
        nxt_first = firstFf;
        nxt_pendAddr = pendAddrFf;
        nxt_pendRegion = pendRegionFf;
        nxt_pendLane = pendLaneFf;
        nxt_readPend = readPendFf;
        nxt_readDone = readDoneFf | (complete && readPendFf);
        nxt_readBurst = readBurstFf;
        push = 1'b0;
        case (stateFf)
            S_IDLE: begin
                nxt_devselN = 1'b1;
                nxt_ctlOe = 1'b0;
                if (addrPhase && hit[2]) begin
                    // Claim and capture the address
                    nxt_ctlOe = 1'b1;
                    nxt_devselN = 1'b0;
                    nxt_region = hit[1:0];
                    nxt_phaseAddr = {adIn[31:2], 2'b00};
                    nxt_waitCnt = 5'h00;
                    nxt_first = 1'b1;
                    if (cbeN[`PTB_CMD_WRITE_BIT]) begin
                        if (bufCountFf != 2'h0 || readPendFf || coolFf) begin
                            // Busy owner keeps its region on the status pins
                            nxt_region = regionFf;
                            nxt_state = S_RETRY;
                            nxt_stopN = 1'b0;
                        end else begin
                            nxt_state = S_WDATA;
                            nxt_trdyN = 1'b0;
                        end
                    end else if (bufCountFf != 2'h0 || coolFf ||
                        (readPendFf && pendRegionFf != hit[1:0])) begin
                        nxt_region = regionFf;
                        nxt_state = S_RETRY;
                        nxt_stopN = 1'b0;
                    end else if (readPendFf && readDoneFf) begin
                        // Fetched data answers any reader of the region
                        nxt_state = S_RDATA;
                        nxt_trdyN = 1'b0;
                        nxt_adOe = 1'b1;
                        nxt_adOut = passthruDataBufferFf;
                    end else if (readPendFf) begin
                        nxt_state = S_RWAIT;
                    end else begin
                        nxt_state = S_RWAIT;
                        nxt_readPend = 1'b1;
                        nxt_readDone = 1'b0;
                        nxt_readBurst = 1'b0;
                        nxt_pendRegion = hit[1:0];
                        nxt_pendAddr = {adIn[31:2], 2'b00};
                    end
                end
            end
            S_WDATA: begin
                if (xfer) begin
                    push = 1'b1;
                    nxt_phaseAddr = stepAddr;
                    nxt_waitCnt = 5'h00;
                    nxt_first = 1'b0;
                    if (frameN) begin
                        // Last phase taken, bus released
                        nxt_state = S_IDLE;
                        nxt_devselN = 1'b1;
                    end else if (!stepInRegion) begin
                        nxt_state = S_RETRY;
                        nxt_stopN = 1'b0;
                    end else begin
                        nxt_trdyN = !((nxtCountPush) < 2'h2);
                    end
                end else if (room) begin
                    nxt_trdyN = 1'b0;
                end else if (timeout) begin
                    nxt_state = S_RETRY;
                    nxt_stopN = 1'b0;
                end
            end
            S_RWAIT: begin
                if (!irdyN) begin
                    nxt_pendLane = cbeN;
                    if (!frameN) begin
                        nxt_readBurst = 1'b1;
                    end
                end
                if (readDoneFf) begin
                    nxt_state = S_RDATA;
                    nxt_trdyN = 1'b0;
                    nxt_adOe = 1'b1;
                    nxt_adOut = passthruDataBufferFf;
                end else if (timeout) begin
                    // Request stays open for the repeated read
                    nxt_state = S_RETRY;
                    nxt_stopN = 1'b0;
                end
            end
            S_RDATA: begin
                nxt_adOe = 1'b1;
                nxt_trdyN = 1'b0;
                if (xfer) begin
                    nxt_readPend = 1'b0;
                    nxt_readDone = 1'b0;
                    nxt_phaseAddr = stepAddr;
                    nxt_waitCnt = 5'h00;
                    nxt_first = 1'b0;
                    nxt_trdyN = 1'b1;
                    nxt_adOe = 1'b0;
                    if (frameN) begin
                        nxt_state = S_IDLE;
                        nxt_devselN = 1'b1;
                    end else if (!stepInRegion) begin
                        nxt_state = S_RETRY;
                        nxt_stopN = 1'b0;
                    end else begin
                        // Ask the add-on for the following phase
                        nxt_state = S_RWAIT;
                        nxt_readPend = 1'b1;
                        nxt_readBurst = 1'b1;
                        nxt_pendAddr = stepAddr;
                    end
                end
            end
            S_RETRY: begin
                nxt_stopN = 1'b0;
                if (frameN) begin
                    nxt_state = S_IDLE;
                    nxt_stopN = 1'b1;
                    nxt_devselN = 1'b1;
                end
            end
            default: begin
                nxt_state = S_IDLE;
                nxt_devselN = 1'b1;
            end
        endcase
    end

    // PCI side registers
    always @(posedge clk) begin
        if (!rst_n) begin
            stateFf <= S_IDLE;
            frameDlyFf <= 1'b1;
            devselNFf <= 1'b1;
            trdyNFf <= 1'b1;
            stopNFf <= 1'b1;
            ctlOeFf <= 1'b0;
            adOeFf <= 1'b0;
            adOutFf <= 32'h0000_0000;
            phaseAddrFf <= 32'h0000_0000;
            regionFf <= 2'h0;
            waitCntFf <= 5'h00;
            firstFf <= 1'b1;
            readPendFf <= 1'b0;
            readDoneFf <= 1'b0;
            readBurstFf <= 1'b0;
            pendRegionFf <= 2'h0;
            pendAddrFf <= 32'h0000_0000;
            pendLaneFf <= 4'hF;
            coolFf <= 1'b0;
        end else if (clkEn) begin
            stateFf <= nxt_state;
            frameDlyFf <= frameN;
            devselNFf <= nxt_devselN;
            trdyNFf <= nxt_trdyN;
            stopNFf <= nxt_stopN;
            ctlOeFf <= nxt_ctlOe;
            adOeFf <= nxt_adOe;
            adOutFf <= nxt_adOut;
            phaseAddrFf <= nxt_phaseAddr;
            regionFf <= nxt_region;
            waitCntFf <= nxt_waitCnt;
            firstFf <= nxt_first;
            readPendFf <= nxt_readPend;
            readDoneFf <= nxt_readDone;
            readBurstFf <= nxt_readBurst;
            pendRegionFf <= nxt_pendRegion;
            pendAddrFf <= nxt_pendAddr;
            pendLaneFf <= nxt_pendLane;
            coolFf <= complete;
        end
    end

    // Two-entry write buffer; head stays put until completion pops it
    always @(posedge clk) begin
        if (!rst_n) begin
            wrPtrFf <= 1'b0;
            rdPtrFf <= 1'b0;
            bufCountFf <= 2'h0;
        end else if (clkEn) begin
            if (push) begin
                bufMem[wrPtrFf] <= pushEntry;
                wrPtrFf <= ~wrPtrFf;
            end
            if (pop) begin
                rdPtrFf <= ~rdPtrFf;
            end
            bufCountFf <= nxtCount;
        end
    end

    // Status outputs; region and direction hold through the attention window, read lanes and burst load from the bus after it opens
    always @(posedge clk) begin
        if (!rst_n) begin
            attnNFf <= 1'b1;
            burstNFf <= 1'b1;
            wrDirFf <= 1'b0;
            regionIdFf <= 2'h0;
            laneOutFf <= 4'hF;
        end else if (clkEn) begin
            // Completion at an edge drops attention at that edge unless a second write stays buffered
            attnNFf <= !((nxtCount != 2'h0) ||
                (nxt_readPend && !nxt_readDone));
            if (nxtCount != 2'h0) begin
                wrDirFf <= 1'b1;
                regionIdFf <= nxt_region;
                laneOutFf <= nxtHead[67:64];
                burstNFf <= !nxtHead[68];
            end else if (nxt_readPend && !nxt_readDone) begin
                wrDirFf <= 1'b0;
                regionIdFf <= nxt_pendRegion;
                laneOutFf <= nxt_pendLane;
                burstNFf <= !nxt_readBurst;
            end else begin
                burstNFf <= 1'b1;
            end
        end
    end

    // Byte-lane writes into the data buffer by the add-on
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
            always @(posedge clk) begin
                if (!rst_n) begin
                    passthruDataBufferFf[lane*8 +: 8] <=
                        DATA_RST[lane*8 +: 8];
                end else if (clkEn && addonWrite &&
                    !addonLaneEnablesN[lane]) begin
                    passthruDataBufferFf[lane*8 +: 8] <=
                        addonDataIn[lane*8 +: 8];
                end
            end
        end
    endgenerate

    // Add-on data bus; address select needs no clock edge
    assign addonDataOut = !addressOutputSelectN ? holderAddr : regData;
    assign addonDataOe = !addressOutputSelectN || addonRead;

    assign adOut = adOutFf;
    assign adOe = adOeFf;
    assign devselN = devselNFf;
    assign trdyN = trdyNFf;
    assign stopN = stopNFf;
    assign pciCtlOe = ctlOeFf;
    assign passthruAttentionN = attnNFf;
    assign burstIndicatorN = burstNFf;
    assign regionIdentifier = regionIdFf;
    assign laneEnableOutputsN = laneOutFf;
    assign writeDirection = wrDirFf;

endmodule

// file: verification/ptb_bridge_sva.sv
// Pin-level checks of the pass-through bridge
`timescale 1ns/10ps
`include "ptb_regs.vh"

module ptb_bridge_sva (
    // Clock, reset and PCI pins
    input wire clk,
    input wire rst_n,
    input wire frameN,
    input wire irdyN,
    input wire [31:0] adIn,
    input wire [3:0] cbeN,
    input wire devselN,
    input wire trdyN,
    input wire stopN,
    // Add-on pins
    input wire addonSelectN,
    input wire addonRdN,
    input wire [6:2] addonAdr,
    input wire addonDataOe,
    input wire addressOutputSelectN,
    input wire addonCompletionN,
    input wire passthruAttentionN,
    input wire [1:0] regionIdentifier,
    input wire writeDirection
);
    reg cmdWr_ff;
    reg later_ff;
    reg [4:0] waitCnt_ff;
    wire hit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Any of the four windows claims the address
    assign hit = ((adIn & `PTB_RGN0_MASK) == `PTB_RGN0_BASE) ||
        ((adIn & `PTB_RGN1_MASK) == `PTB_RGN1_BASE) ||
        ((adIn & `PTB_RGN2_MASK) == `PTB_RGN2_BASE) ||
        ((adIn & `PTB_RGN3_MASK) == `PTB_RGN3_BASE);

    // Command kind and target wait, so a stall can be bounded per phase
    always @(posedge clk) begin
        if ($fell(frameN)) begin
            cmdWr_ff <= cbeN[`PTB_CMD_WRITE_BIT];
        end
        if (!rst_n || devselN || !stopN || !trdyN) begin
            waitCnt_ff <= 5'h00;
        end else begin
            waitCnt_ff <= waitCnt_ff + 5'h01;
        end
        if (!rst_n || devselN) begin
            later_ff <= 1'b0;
        end else if (!trdyN && !irdyN) begin
            later_ff <= 1'b1;
        end
    end

    sequence claimSeq;
        $fell(frameN) && hit;
    endsequence
    sequence lastWrSeq;
        !devselN && !trdyN && !irdyN && frameN && cmdWr_ff;
    endsequence

    idle_after_reset_a: assert property (disable iff (1'b0)
        !rst_n |=> devselN && trdyN && stopN && passthruAttentionN)
        else $error("bridge not idle after reset");
    region_claim_a: assert property (claimSeq |=> !devselN)
        else $error("region hit not claimed");
    write_trdy_a: assert property (
        $fell(devselN) && stopN && cmdWr_ff |-> !trdyN)
        else $error("write not accepted at once");
    write_release_a: assert property (lastWrSeq |=> devselN)
        else $error("bus held after captured write");
    read_trdy_wait_a: assert property (
        $fell(trdyN) && !cmdWr_ff |-> passthruAttentionN)
        else $error("read data given before completion");
    phase_timeout_a: assert property (
        waitCnt_ff <= (later_ff ? 5'h08 : 5'h10))
        else $error("data phase stalled past limit");
    busy_write_retry_a: assert property (
        $fell(devselN) && !passthruAttentionN && writeDirection
        |-> !stopN) else $error("claim not retried while busy");
    read_done_drop_a: assert property (
        !passthruAttentionN && !addonCompletionN && !writeDirection
        |=> passthruAttentionN) else $error("attention kept after done");
    status_hold_a: assert property (
        !passthruAttentionN && addonCompletionN |=> !passthruAttentionN
        && $stable(regionIdentifier) && $stable(writeDirection))
        else $error("status moved before completion");
    addr_drive_a: assert property (
        !addressOutputSelectN |-> addonDataOe)
        else $error("address select not driving data bus");
    data_drive_a: assert property (
        !addonSelectN && !addonRdN && addonAdr == 5'h0B
        && addressOutputSelectN |-> addonDataOe)
        else $error("buffer read not driving data bus");
endmodule

bind ptb_bridge ptb_bridge_sva chk (.*);

// file: verification/ptb_addon_model.sv
// Behavioural add-on logic answering the pass-through handshake
`timescale 1ns/10ps

module ptb_addon_model #(
    parameter [31:0] KEY = 32'h5A5A_0000
) (
    // Clock, reset and bridge status
    input wire clk,
    input wire rst_n,
    input wire passthruAttentionN,
    input wire writeDirection,
    input wire [31:0] addonDataOut,
    input wire [7:0] dly,
    // Add-on drive
    output reg addonSelectN,
    output reg addonRdN,
    output reg addonWrN,
    output reg [6:2] addonAdr,
    output reg [31:0] addonDataIn,
    output reg addressOutputSelectN,
    output reg addonCompletionN,
    // What the add-on saw
    output reg [31:0] lastAddr,
    output reg [31:0] lastWord,
    output reg [7:0] words
);
    reg [7:0] step_ff;
    wire [7:0] sStp;
    wire [7:0] endStp;

    // Writes fetch the holder first; reads go straight to the buffer
    assign sStp = writeDirection ? 8'h02 : 8'h00;
    assign endStp = sStp + dly + 8'h01;

    // One word per pass; dly stretches the strobe and delays completion
    always @(posedge clk) begin
        if (!rst_n) begin
            step_ff <= 8'h00;
            words <= 8'h00;
            {addonSelectN, addonRdN, addonWrN} <= 3'h7;
            addressOutputSelectN <= 1'b1;
            addonCompletionN <= 1'b1;
            addonAdr <= 5'h00;
        end else if (step_ff != 8'h00 || !passthruAttentionN) begin
            step_ff <= (step_ff == endStp) ? 8'h00 : step_ff + 8'h01;
            if (writeDirection && step_ff == 8'h00) begin
                addressOutputSelectN <= 1'b0;
            end
            // Strobes start a step after select rises, never beside it
            if (writeDirection && step_ff == 8'h01) begin
                lastAddr <= addonDataOut;
                addressOutputSelectN <= 1'b1;
            end
            if (step_ff == sStp) begin
                addonSelectN <= 1'b0;
                addonAdr <= 5'h0B;
                addonRdN <= !writeDirection;
                addonWrN <= writeDirection;
                addonDataIn <= KEY + words;
            end
            if (step_ff == sStp + dly) begin
                addonCompletionN <= 1'b0;
            end
            // Released data lines flip so a stale word cannot match
            if (step_ff == endStp) begin
                lastWord <= addonDataOut;
                words <= words + 8'h01;
                {addonSelectN, addonRdN, addonWrN} <= 3'h7;
                addonCompletionN <= 1'b1;
                addonDataIn <= ~addonDataIn;
            end
        end
    end
endmodule

// file: verification/ptb_bridge_tb_top.sv
// Self-checking bench for the pass-through bridge
`timescale 1ns/10ps

module ptb_bridge_tb_top;
    localparam [31:0] KEY = 32'h5A5A_0000;
    reg clk, rst_n, frameN, irdyN;
    reg [31:0] adIn;
    reg [3:0] cbeN;
    reg [7:0] dly, w, stat;
    reg [31:0] rdBuf [0:3];
    int got, err_total, comparisons;
    bit retried;
    wire clkEn = 1'b1;
    wire [3:0] addonLaneEnablesN = 4'h0;
    wire [31:0] adOut, addonDataOut, addonDataIn, lastAddr, lastWord;
    wire [7:0] words;
    wire [6:2] addonAdr;
    wire [1:0] regionIdentifier;
    wire [3:0] laneEnableOutputsN;
    wire adOe, devselN, trdyN, stopN, pciCtlOe, addonDataOe;
    wire addonSelectN, addonRdN, addonWrN, addressOutputSelectN;
    wire addonCompletionN, passthruAttentionN, burstIndicatorN;
    wire writeDirection;

    ptb_bridge dut (.*);
    ptb_addon_model #(.KEY(KEY)) addon (.*);

    always #25 clk = ~clk;

    // Last status shown while attention was low
    always @(posedge clk) begin
        if (!passthruAttentionN) begin
            stat <= {burstIndicatorN, regionIdentifier, writeDirection,
                laneEnableOutputsN};
        end
    end

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            comparisons++;
            if (seen !== exp) begin
                err_total++;
                $display("CHECK FAILED at %0t: %h not %h", $time, seen, exp);
            end
        end
    endtask

    // One PCI transaction of n phases; stops on retry or transfer count
    task automatic pci(input [31:0] a, input bit wr, input int n,
        input [31:0] d);
        int t;
        bit fin;
        begin
            got = 0;
            retried = 0;
            fin = 0;
            @(posedge clk);
            frameN <= 1'b0;
            adIn <= a;
            cbeN <= wr ? 4'h7 : 4'h6;
            @(posedge clk);
            frameN <= (n == 1);
            irdyN <= 1'b0;
            adIn <= d;
            cbeN <= 4'h0;
            for (t = 0; t < 40 && !fin; t++) begin
                @(posedge clk);
                if (!stopN) begin
                    retried = 1;
                    fin = frameN;
                    frameN <= 1'b1;
                end else if (!trdyN && !irdyN) begin
                    rdBuf[got] = adOut;
                    got++;
                    adIn <= d + got;
                    fin = (got == n);
                    if (got == n - 1) begin
                        frameN <= 1'b1;
                    end
                end
                if (fin) begin
                    irdyN <= 1'b1;
                end
            end
            if (!fin) begin
                @(posedge clk);
                frameN <= 1'b1;
                irdyN <= 1'b1;
            end
        end
    endtask

    // Waits for the add-on count, then the cooling gap
    task automatic waitWords(input [7:0] n);
        int t;
        begin
            for (t = 0; t < 300 && words !== n; t++) begin
                @(posedge clk);
            end
            chk(words, n);
            repeat (3) @(posedge clk);
        end
    endtask

    task t_write;
        begin
            chk({devselN, trdyN, stopN, pciCtlOe, adOe}, 5'h1C);
            chk({passthruAttentionN, burstIndicatorN, writeDirection,
                laneEnableOutputsN}, 7'h6F);
            dly <= 8'h06;
            w = words;
            pci(32'h000D_C010, 1, 1, 32'hCAFE_0001);
            chk(got, 1);
            chk(words, w);
            waitWords(w + 8'h01);
            chk(lastWord, 32'hCAFE_0001);
            chk(lastAddr, 32'h000D_C010);
            chk(stat, 8'hB0);
            pci(32'h0010_0000, 1, 1, 32'h0);
            chk(got + retried, 0);
            $display("test write done");
        end
    endtask

    task t_busy;
        begin
            dly <= 8'h14;
            w = words;
            pci(32'h000C_0004, 1, 1, 32'h1111_2222);
            chk(got, 1);
            pci(32'h000E_0000, 1, 1, 32'h3333_4444);
            chk(retried, 1);
            chk(got, 0);
            pci(32'h000D_C204, 0, 1, 32'h0);
            chk(retried, 1);
            waitWords(w + 8'h01);
            chk(lastWord, 32'h1111_2222);
            chk(lastAddr, 32'h000C_0004);
            $display("test busy done");
        end
    endtask

    task t_read;
        begin
            dly <= 8'h00;
            w = words;
            pci(32'h000C_0100, 0, 1, 32'h0);
            chk(got, 1);
            chk(rdBuf[0], KEY + w);
            waitWords(w + 8'h01);
            chk(stat, 8'h80);
            dly <= 8'h1E;
            w = words;
            pci(32'h000D_C204, 0, 1, 32'h0);
            chk(retried, 1);
            chk(got, 0);
            pci(32'h000E_0010, 0, 1, 32'h0);
            chk(retried, 1);
            waitWords(w + 8'h01);
            pci(32'h000D_C204, 0, 1, 32'h0);
            chk(got, 1);
            chk(rdBuf[0], KEY + w);
            $display("test read done");
        end
    endtask

    task t_burst;
        int i;
        begin
            dly <= 8'h00;
            w = words;
            pci(32'h000D_C1F8, 1, 4, 32'hB000_0000);
            chk(got, 2);
            chk(retried, 1);
            waitWords(w + 8'h02);
            chk(lastWord, 32'hB000_0001);
            chk(lastAddr, 32'h000D_C1FC);
            chk(stat[7], 1'b0);
            pci(32'h000D_C200, 1, 1, 32'hB000_0002);
            chk(got, 1);
            waitWords(w + 8'h03);
            w = words;
            pci(32'h000E_0100, 0, 3, 32'h0);
            chk(got, 3);
            for (i = 0; i < 3; i++) begin
                chk(rdBuf[i], KEY + w + i);
            end
            chk(stat[7], 1'b0);
            $display("test burst done");
        end
    endtask

    task end_sim;
        begin
            $display("%0d checks, %0d mismatches", comparisons, err_total);
            if (err_total == 0 && comparisons > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    // Tests need a few hundred cycles; 20000 means a hang
    initial begin
        #1000000;
        err_total++;
        end_sim();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        frameN = 1'b1;
        irdyN = 1'b1;
        adIn = 32'h0;
        cbeN = 4'hF;
        dly = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_write();
        t_busy();
        t_read();
        t_burst();
        end_sim();
    end
endmodule
